// ---- dv/dsp_memory_map_decoder_test.sv ----
// self-checking testbench of the memory map decoder
`timescale 1ns/100ps
`default_nettype none
`include "mmd_cfg.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module dsp_memory_map_decoder_test
    import mmd_pkg::*;
;
    // stimulus and answer signals
    logic           sys_clk, reset, pin, sec_rr, sec_ro;
    logic           prog_req, prog_data_read, fetch_from_rom, data_req, data_we, vec_req, host_req, host_we;
    logic [15:0]    prog_addr, data_addr, data_wdata, host_addr, reg_rdata, pc_value, mode_status;
    logic [4:0]     vec_num;
    logic           prog_valid, prog_force_ones, data_valid, pc_load, host_grant, host_refused;
    logic           emu_enable, bscan_enable;
    mmd_target_type prog_target, data_target;
    logic [2:0]     prog_block, data_block;
    logic [22:0]    prog_full_addr;
    logic [6:0]     page_select;
    int             miscompares, n_compared;
    localparam logic [15:0] m_base = 16'hFF80, m_overlay = 16'hFFA0, m_romoff = 16'hFFC0, m_datamap = 16'hFF88;

    // design and requester
    mmd_decoder DUT (.sys_clk(sys_clk), .reset(reset), .rom_enable_mode_pin(pin), .secure_ram_rom(sec_rr),
        .secure_rom_only(sec_ro), .prog_req(prog_req), .prog_addr(prog_addr), .prog_data_read(prog_data_read),
        .fetch_from_rom(fetch_from_rom), .data_req(data_req), .data_we(data_we), .data_addr(data_addr),
        .data_wdata(data_wdata), .vec_req(vec_req), .vec_num(vec_num), .host_req(host_req), .host_we(host_we),
        .host_addr(host_addr), .prog_valid(prog_valid), .prog_target(prog_target), .prog_block(prog_block),
        .prog_full_addr(prog_full_addr), .prog_force_ones(prog_force_ones), .data_valid(data_valid),
        .data_target(data_target), .data_block(data_block), .reg_rdata(reg_rdata), .pc_load(pc_load),
        .pc_value(pc_value), .host_grant(host_grant), .host_refused(host_refused), .page_select(page_select),
        .mode_status(mode_status), .emu_enable(emu_enable), .bscan_enable(bscan_enable));
    mmd_core_model u_core (.sys_clk(sys_clk), .prog_req(prog_req), .prog_addr(prog_addr),
        .prog_data_read(prog_data_read), .fetch_from_rom(fetch_from_rom), .data_req(data_req), .data_we(data_we),
        .data_addr(data_addr), .data_wdata(data_wdata), .vec_req(vec_req), .vec_num(vec_num),
        .host_req(host_req), .host_we(host_we), .host_addr(host_addr));

    // 100 MHz clock
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    // counts, verdict and end of run
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // reset with strap and options, then judge the boot cycle
    task automatic do_reset(input logic p, input logic rr, input logic ro);
        @(posedge sys_clk);
        {reset, pin, sec_rr, sec_ro} <= {1'h1, p, rr, ro};
        repeat (5) @(posedge sys_clk);
        reset <= 1'h0;
        @(posedge sys_clk);
        #1;
        `CHK(pc_load, 1'h1)
        `CHK(pc_value, 16'hFF80)
        `CHK(mode_status, {9'h1FF, rr ? 1'h0 : p, 6'h00})
        `CHK(page_select, 7'h00)
        `CHK(emu_enable, ~(rr | ro))
        `CHK(bscan_enable, 1'h1)
        $display("reset done, options %0h %0h", rr, ro);
    endtask : do_reset

    // load mode status and page select
    task automatic set_regs(input logic [15:0] m, input logic [6:0] p);
        u_core.data_acc(1'h1, `MMD_MODE_STAT_ADDR, m);
        u_core.data_acc(1'h1, `MMD_PAGE_SEL_ADDR, {9'h000, p});
    endtask : set_regs

    // one program decode case, read by code from outside rom
    task automatic prog_case(input logic [15:0] m, input logic [6:0] p, input logic [15:0] a,
                             input mmd_target_type t, input logic [2:0] b);
        set_regs(m, p);
        u_core.prog_acc(a, 1'h1, 1'h0);
        `CHK(prog_valid, 1'h1)
        `CHK(prog_target, t)
        `CHK(prog_full_addr, {p, a})
        `CHK(prog_force_ones, 1'h0)
        if (t == MMD_TGT_DUAL || t == MMD_TGT_SINGLE) `CHK(prog_block, b)
    endtask : prog_case

    // one data decode case
    task automatic data_case(input logic [15:0] m, input logic [6:0] p, input logic [15:0] a,
                             input mmd_target_type t, input logic [2:0] b);
        set_regs(m, p);
        u_core.data_acc(1'h0, a, 16'h0000);
        `CHK(data_valid, 1'h1)
        `CHK(data_target, t)
        if (t == MMD_TGT_DUAL) `CHK(data_block, b)
    endtask : data_case

    // one host access, granted or refused
    task automatic host_case(input logic we, input logic [15:0] a, input logic g);
        u_core.host_acc(we, a);
        `CHK(host_grant, g)
        `CHK(host_refused, ~g)
    endtask : host_case

    // page register write, read back and extended address
    task automatic t_page();
        u_core.data_acc(1'h1, `MMD_PAGE_SEL_ADDR, 16'hFF85);
        `CHK(page_select, 7'h05)
        u_core.data_acc(1'h0, `MMD_PAGE_SEL_ADDR, 16'h0000);
        `CHK(data_target, MMD_TGT_REG)
        `CHK(reg_rdata, 16'h0005)
        u_core.prog_acc(16'h1234, 1'h0, 1'h0);
        `CHK(prog_full_addr, 23'h051234)
        `CHK(prog_target, MMD_TGT_EXT)
        u_core.data_acc(1'h1, `MMD_MODE_STAT_ADDR, m_datamap);
        u_core.data_acc(1'h0, `MMD_MODE_STAT_ADDR, 16'h0000);
        `CHK(reg_rdata, m_datamap)
        $display("test page done");
    endtask : t_page

    // program space map over pages and mode bits
    task automatic t_prog_map();
        prog_case(m_base, 7'h00, 16'hC000, MMD_TGT_ROM, 3'h0);
        prog_case(m_base, 7'h00, 16'hFF80, MMD_TGT_ROM, 3'h0);
        prog_case(m_base, 7'h00, 16'h1000, MMD_TGT_EXT, 3'h0);
        prog_case(m_base, 7'h01, 16'h8000, MMD_TGT_DUAL, 3'h4);
        prog_case(m_base, 7'h01, 16'hFFFF, MMD_TGT_DUAL, 3'h7);
        prog_case(m_base, 7'h01, 16'h7FFF, MMD_TGT_EXT, 3'h0);
        prog_case(m_base, 7'h02, 16'h8000, MMD_TGT_SINGLE, 3'h0);
        prog_case(m_base, 7'h03, 16'hBFFF, MMD_TGT_SINGLE, 3'h5);
        prog_case(m_base, 7'h04, 16'h8000, MMD_TGT_EXT, 3'h0);
        prog_case(m_overlay, 7'h00, 16'h2000, MMD_TGT_DUAL, 3'h1);
        prog_case(m_overlay, 7'h00, 16'h007F, MMD_TGT_EXT, 3'h0);
        prog_case(m_overlay, 7'h03, 16'h0080, MMD_TGT_DUAL, 3'h0);
        prog_case(m_romoff, 7'h00, 16'hC000, MMD_TGT_EXT, 3'h0);
        $display("test program map done");
    endtask : t_prog_map

    // data space map with and without the mapping bit
    task automatic t_data_map();
        data_case(m_base, 7'h00, 16'h0040, MMD_TGT_REG, 3'h0);
        data_case(m_base, 7'h00, 16'h0080, MMD_TGT_DUAL, 3'h0);
        data_case(m_base, 7'h05, 16'h6000, MMD_TGT_DUAL, 3'h3);
        data_case(m_base, 7'h00, 16'h8000, MMD_TGT_EXT, 3'h0);
        data_case(m_datamap, 7'h00, 16'h8000, MMD_TGT_DUAL, 3'h4);
        data_case(m_datamap, 7'h01, 16'hE000, MMD_TGT_DUAL, 3'h7);
        data_case(m_base, 7'h00, 16'hC000, MMD_TGT_EXT, 3'h0);
        $display("test data map done");
    endtask : t_data_map

    // vectors from the reset page and from a moved pointer
    task automatic t_vectors();
        set_regs(m_base, 7'h00);
        u_core.vec_acc(5'h02);
        `CHK(pc_load, 1'h1)
        `CHK(pc_value, 16'hFF88)
        set_regs(16'h0100, 7'h00);
        u_core.vec_acc(5'h03);
        `CHK(pc_value, 16'h010C)
        u_core.vec_acc(5'h1F);
        `CHK(pc_value, 16'h017C)
        $display("test vectors done");
    endtask : t_vectors

    // ram/rom security option
    task automatic t_sec_ram_rom();
        do_reset(1'h1, 1'h1, 1'h0);
        set_regs(m_base, 7'h00);
        u_core.prog_acc(16'hC000, 1'h1, 1'h0);
        `CHK(prog_force_ones, 1'h1)
        u_core.prog_acc(16'hC000, 1'h1, 1'h1);
        `CHK(prog_force_ones, 1'h0)
        u_core.prog_acc(16'hC000, 1'h0, 1'h0);
        `CHK(prog_target, MMD_TGT_ROM)
        set_regs(m_romoff, 7'h01);
        `CHK(mode_status, m_romoff)
        u_core.prog_acc(16'h8000, 1'h1, 1'h0);
        `CHK(prog_force_ones, 1'h0)
        `CHK(prog_target, MMD_TGT_DUAL)
        host_case(1'h0, 16'h6000, 1'h0);
        host_case(1'h0, 16'h4000, 1'h1);
        host_case(1'h0, 16'h5FFF, 1'h1);
        host_case(1'h0, 16'h3FFF, 1'h0);
        host_case(1'h1, 16'h6000, 1'h1);
        $display("test ram rom option done");
    endtask : t_sec_ram_rom

    // rom-only security option
    task automatic t_sec_rom_only();
        do_reset(1'h1, 1'h0, 1'h1);
        set_regs(m_base, 7'h00);
        u_core.prog_acc(16'hC000, 1'h1, 1'h0);
        `CHK(prog_force_ones, 1'h1)
        host_case(1'h0, 16'h6000, 1'h1);
        host_case(1'h1, 16'h0000, 1'h1);
        $display("test rom only option done");
    endtask : t_sec_rom_only

    // main sequence
    initial begin
        {reset, pin, sec_rr, sec_ro} = 4'h8;
        do_reset(1'h0, 1'h0, 1'h0);
        t_page();
        t_prog_map();
        t_data_map();
        t_vectors();
        t_sec_ram_rom();
        t_sec_rom_only();
        conclude();
    end

    // hang limit
    initial begin
        repeat (100000) @(posedge sys_clk);
        miscompares++;
        conclude();
    end
endmodule : dsp_memory_map_decoder_test
`default_nettype wire

// ---- dv/mmd_core_model.sv ----
// requester model of the core address generators and host port
`timescale 1ns/100ps
`default_nettype none
module mmd_core_model (
    // clock
    input  wire logic   sys_clk,
    // program requester
    output logic        prog_req,
    output logic [15:0] prog_addr,
    output logic        prog_data_read,
    output logic        fetch_from_rom,
    // data requester
    output logic        data_req,
    output logic        data_we,
    output logic [15:0] data_addr,
    output logic [15:0] data_wdata,
    // vector requester
    output logic        vec_req,
    output logic [4:0]  vec_num,
    // host port requester
    output logic        host_req,
    output logic        host_we,
    output logic [15:0] host_addr
);
    // idle at time zero
    initial begin
        {prog_req, prog_addr, prog_data_read, fetch_from_rom, data_req, data_we} = '0;
        {data_addr, data_wdata, vec_req, vec_num, host_req, host_we, host_addr} = '0;
    end

    // one program access; the released address shows the inverse of the last value
    task automatic prog_acc(input logic [15:0] a, input logic rd, input logic fr);
        @(posedge sys_clk);
        {prog_req, prog_addr, prog_data_read, fetch_from_rom} <= {1'h1, a, rd, fr};
        @(posedge sys_clk);
        {prog_req, prog_addr} <= {1'h0, ~a};
        #1;
    endtask : prog_acc

    // one data access; released address and data lines show the inverse of the last value
    task automatic data_acc(input logic we, input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        {data_req, data_we, data_addr, data_wdata} <= {1'h1, we, a, d};
        @(posedge sys_clk);
        {data_req, data_addr, data_wdata} <= {1'h0, ~a, ~d};
        #1;
    endtask : data_acc

    // one vector request
    task automatic vec_acc(input logic [4:0] n);
        @(posedge sys_clk);
        {vec_req, vec_num} <= {1'h1, n};
        @(posedge sys_clk);
        {vec_req, vec_num} <= {1'h0, ~n};
        #1;
    endtask : vec_acc

    // one host port access
    task automatic host_acc(input logic we, input logic [15:0] a);
        @(posedge sys_clk);
        {host_req, host_we, host_addr} <= {1'h1, we, a};
        @(posedge sys_clk);
        {host_req, host_addr} <= {1'h0, ~a};
        #1;
    endtask : host_acc
endmodule : mmd_core_model
`default_nettype wire

// ---- src/mmd_cfg.svh ----
// address map, register layout and reset constants of the memory map decoder
`ifndef MMD_CFG_SVH
`define MMD_CFG_SVH

// register addresses in data space
`define MMD_PAGE_SEL_ADDR   16'h001E
`define MMD_MODE_STAT_ADDR  16'h001D

// mode status field positions
`define MMD_VPTR_HI         15
`define MMD_VPTR_LO         7
`define MMD_ROMEN_BIT       6
`define MMD_OVERLAY_BIT     5
`define MMD_ADDRVIS_BIT     4
`define MMD_DATAMAP_BIT     3
`define MMD_CLKOUT_OFF_BIT  2

// reset values
`define MMD_MODE_RESET      16'hFF80
`define MMD_PAGE_RESET      7'h00
`define MMD_RESET_VECTOR    16'hFF80

// program space layout
`define MMD_PAGE_BASE       7'h00
`define MMD_PAGE_DUAL_HI    7'h01
`define MMD_PAGE_SINGLE_A   7'h02
`define MMD_PAGE_SINGLE_B   7'h03
`define MMD_ROM_BASE        16'hC000
`define MMD_DUAL_LO         16'h0080
`define MMD_BLK_HI          15
`define MMD_BLK_LO          13
`define MMD_BLK_MID         14

// vector forming
`define MMD_VEC_OFS_ZERO    7'h00
`define MMD_VEC_PAD         2'h0

// host read window under the ram/rom option
`define MMD_HOST_RD_LO      16'h4000
`define MMD_HOST_RD_HI      16'h5FFF

// misc data values
`define MMD_ALL_ONES        16'hFFFF
`define MMD_PAGE_PAD        9'h000
`define MMD_ZERO_WORD       16'h0000
`define MMD_ZERO_BLK        3'h0

`endif

// ---- src/mmd_data_decode.sv ----
// data space address decoder
`timescale 1ns/100ps
`default_nettype none
`include "mmd_cfg.svh"
module mmd_data_decode
    import mmd_pkg::*;
(
    // mapping controls
    mmd_map_if.dec              map,
    // address in
    input  wire logic [15:0]    addr,
    // decode result
    output mmd_target_type      target,
    output logic [2:0]          block
);

    // sixteen-bit decode, page select never consulted and rom never reached
    always_comb begin
        target = MMD_TGT_EXT;
        block  = addr[`MMD_BLK_HI:`MMD_BLK_LO];
        if (addr < `MMD_DUAL_LO) begin
            target = MMD_TGT_REG;
            block  = `MMD_ZERO_BLK;
        end else if (!addr[`MMD_BLK_HI]) begin
            target = MMD_TGT_DUAL;
        end else if (map.datamap) begin
            target = MMD_TGT_DUAL;
        end
    end

endmodule : mmd_data_decode
`default_nettype wire

// ---- src/mmd_decoder.sv ----
// memory map decoder top: mode registers, address steering, vectors, security
`timescale 1ns/100ps
`default_nettype none
`include "mmd_cfg.svh"
module mmd_decoder
    import mmd_pkg::*;
(
    // clock and reset
    input  wire logic           sys_clk,
    input  wire logic           reset,
    // mode pin and security options
    input  wire logic           rom_enable_mode_pin,
    input  wire logic           secure_ram_rom,
    input  wire logic           secure_rom_only,
    // program address generator request
    input  wire logic           prog_req,
    input  wire logic [15:0]    prog_addr,
    input  wire logic           prog_data_read,
    input  wire logic           fetch_from_rom,
    // data address generator request
    input  wire logic           data_req,
    input  wire logic           data_we,
    input  wire logic [15:0]    data_addr,
    input  wire logic [15:0]    data_wdata,
    // vector request
    input  wire logic           vec_req,
    input  wire logic [4:0]     vec_num,
    // host port request
    input  wire logic           host_req,
    input  wire logic           host_we,
    input  wire logic [15:0]    host_addr,
    // program decode result
    output logic                prog_valid,
    output mmd_target_type      prog_target,
    output logic [2:0]          prog_block,
    output logic [22:0]         prog_full_addr,
    output logic                prog_force_ones,
    // data decode result
    output logic                data_valid,
    output mmd_target_type      data_target,
    output logic [2:0]          data_block,
    output logic [15:0]         reg_rdata,
    // program counter load
    output logic                pc_load,
    output logic [15:0]         pc_value,
    // host port answer
    output logic                host_grant,
    output logic                host_refused,
    // register and test state
    output logic [6:0]          page_select,
    output logic [15:0]         mode_status,
    output logic                emu_enable,
    output logic                bscan_enable
);

    mmd_state_type  st_reg;
    mmd_state_type  st_next;
    mmd_target_type pdec_target;
    logic [2:0]     pdec_block;
    logic [22:0]    pdec_full;
    mmd_target_type ddec_target;
    logic [2:0]     ddec_block;
    logic           secure_any;
    logic           host_in_window;

    mmd_map_if map_bus ();

    // mapping controls taken from the live registers
    assign map_bus.page    = st_reg.page;
    assign map_bus.overlay = st_reg.mode[`MMD_OVERLAY_BIT];
    assign map_bus.datamap = st_reg.mode[`MMD_DATAMAP_BIT];
    assign map_bus.rom_off = st_reg.mode[`MMD_ROMEN_BIT];

    mmd_prog_decode u_prog_decode (
        .map    (map_bus),
        .addr   (prog_addr),
        .target (pdec_target),
        .block  (pdec_block),
        .full   (pdec_full)
    );

    mmd_data_decode u_data_decode (
        .map    (map_bus),
        .addr   (data_addr),
        .target (ddec_target),
        .block  (ddec_block)
    );

    // security and host window qualifiers
    assign secure_any     = secure_ram_rom || secure_rom_only;
    assign host_in_window = host_addr >= `MMD_HOST_RD_LO && host_addr <= `MMD_HOST_RD_HI;

    // next state: registers, decode capture, vectors, host answer
    always_comb begin
        st_next              = st_reg;
        st_next.boot         = 1'b0;
        st_next.pc_load      = 1'b0;
        st_next.prog_valid   = 1'b0;
        st_next.data_valid   = 1'b0;
        st_next.host_grant   = 1'b0;
        st_next.host_refused = 1'b0;
        st_next.prog_ones    = 1'b0;
        st_next.emu_en       = !secure_any;
        st_next.bscan_en     = 1'b1;
        // register writes through data space
        if (data_req && data_we && data_addr == `MMD_PAGE_SEL_ADDR) begin
            st_next.page = data_wdata[6:0];
        end
        if (data_req && data_we && data_addr == `MMD_MODE_STAT_ADDR) begin
            st_next.mode = data_wdata;
        end
        // data decode capture and register read back
        if (data_req) begin
            st_next.data_valid  = 1'b1;
            st_next.data_target = ddec_target;
            st_next.data_block  = ddec_block;
            st_next.rdata       = `MMD_ZERO_WORD;
            if (!data_we && data_addr == `MMD_PAGE_SEL_ADDR) begin
                st_next.rdata = {`MMD_PAGE_PAD, st_reg.page};
            end else if (!data_we && data_addr == `MMD_MODE_STAT_ADDR) begin
                st_next.rdata = st_reg.mode;
            end
        end
        // program decode capture, secured rom reads give all ones
        if (prog_req) begin
            st_next.prog_valid  = 1'b1;
            st_next.prog_target = pdec_target;
            st_next.prog_block  = pdec_block;
            st_next.prog_full   = pdec_full;
            st_next.prog_ones   = secure_any && prog_data_read && !fetch_from_rom
                                  && pdec_target == MMD_TGT_ROM;
        end
        // first cycle after reset: catch the mode pin and start at the reset vector
        if (st_reg.boot) begin
            st_next.mode[`MMD_ROMEN_BIT] = secure_ram_rom ? 1'b0 : rom_enable_mode_pin;
            st_next.pc_load  = 1'b1;
            st_next.pc_value = {st_reg.mode[`MMD_VPTR_HI:`MMD_VPTR_LO], `MMD_VEC_OFS_ZERO};
        end else if (vec_req) begin
            st_next.pc_load  = 1'b1;
            st_next.pc_value = {st_reg.mode[`MMD_VPTR_HI:`MMD_VPTR_LO], vec_num, `MMD_VEC_PAD};
        end
        // host port: reads outside the window refused under the ram/rom option
        if (host_req) begin
            if (!host_we && secure_ram_rom && !host_in_window) begin
                st_next.host_refused = 1'b1;
            end else begin
                st_next.host_grant = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_reg             <= '0;
            st_reg.boot        <= 1'b1;
            st_reg.page        <= `MMD_PAGE_RESET;
            st_reg.mode        <= `MMD_MODE_RESET;
            st_reg.prog_target <= MMD_TGT_EXT;
            st_reg.data_target <= MMD_TGT_EXT;
            st_reg.bscan_en    <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign prog_valid      = st_reg.prog_valid;
    assign prog_target     = st_reg.prog_target;
    assign prog_block      = st_reg.prog_block;
    assign prog_full_addr  = st_reg.prog_full;
    assign prog_force_ones = st_reg.prog_ones;
    assign data_valid      = st_reg.data_valid;
    assign data_target     = st_reg.data_target;
    assign data_block      = st_reg.data_block;
    assign reg_rdata       = st_reg.rdata;
    assign pc_load         = st_reg.pc_load;
    assign pc_value        = st_reg.pc_value;
    assign host_grant      = st_reg.host_grant;
    assign host_refused    = st_reg.host_refused;
    assign page_select     = st_reg.page;
    assign mode_status     = st_reg.mode;
    assign emu_enable      = st_reg.emu_en;
    assign bscan_enable    = st_reg.bscan_en;

    // checks on the decoder behaviour
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    chk_page_write_load: assert property (
        data_req && data_we && data_addr == `MMD_PAGE_SEL_ADDR |=> page_select == $past(data_wdata[6:0]))
        else $error("page select did not take the written value");

    chk_rom_data_never: assert property (
        data_valid |-> data_target != MMD_TGT_ROM)
        else $error("rom decoded in data space");

    chk_rom_off_external: assert property (
        prog_req && mode_status[`MMD_ROMEN_BIT] && page_select == `MMD_PAGE_BASE
        && prog_addr >= `MMD_ROM_BASE |=> prog_valid && prog_target == MMD_TGT_EXT)
        else $error("rom decoded while disabled");

    chk_boot_vector_start: assert property (
        st_reg.boot |=> pc_load && pc_value == `MMD_RESET_VECTOR)
        else $error("reset vector not loaded at FF80h");

    chk_vector_page_form: assert property (
        vec_req && !st_reg.boot |=> pc_load
        && pc_value == {$past(mode_status[`MMD_VPTR_HI:`MMD_VPTR_LO]), $past(vec_num), `MMD_VEC_PAD})
        else $error("vector address not formed from pointer");

    chk_secure_rom_ones: assert property (
        prog_req && secure_any && prog_data_read && !fetch_from_rom && pdec_target == MMD_TGT_ROM
        |=> prog_force_ones)
        else $error("secured rom read not forced to ones");

    chk_host_read_window: assert property (
        host_req && !host_we && secure_ram_rom && !host_in_window |=> host_refused && !host_grant)
        else $error("host read outside window granted");

    chk_emu_secure_off: assert property (
        secure_any |=> !emu_enable && bscan_enable)
        else $error("emulation left on under security");

    chk_secure_boot_mode: assert property (
        st_reg.boot && secure_ram_rom |=> !mode_status[`MMD_ROMEN_BIT])
        else $error("rom enable bit not forced low");

    chk_single_block_map: assert property (
        prog_req && page_select == `MMD_PAGE_SINGLE_B && prog_addr[`MMD_BLK_HI]
        |=> prog_target == MMD_TGT_SINGLE && prog_block[2])
        else $error("upper single-access block misdecoded");

    // map, register and answer checks
    chk_full_page_concat: assert property (
        prog_req |=> prog_full_addr == {$past(page_select), $past(prog_addr)})
        else $error("page not prefixed to program address");

    chk_page_read_back: assert property (
        data_req && !data_we && data_addr == `MMD_PAGE_SEL_ADDR
        |=> reg_rdata == {`MMD_PAGE_PAD, $past(page_select)})
        else $error("page select read back wrong");

    chk_overlay_page_zero: assert property (
        prog_req && mode_status[`MMD_OVERLAY_BIT] && prog_addr < `MMD_DUAL_LO
        |=> prog_target == MMD_TGT_EXT)
        else $error("data page zero reached program space");

    chk_dual_upper_prog: assert property (
        prog_req && page_select == `MMD_PAGE_DUAL_HI && prog_addr[`MMD_BLK_HI]
        |=> prog_target == MMD_TGT_DUAL && prog_block == $past(prog_addr[`MMD_BLK_HI:`MMD_BLK_LO]))
        else $error("upper dual blocks misdecoded in program space");

    chk_data_low_dual: assert property (
        data_req && data_addr >= `MMD_DUAL_LO && !data_addr[`MMD_BLK_HI]
        |=> data_target == MMD_TGT_DUAL && data_block == $past(data_addr[`MMD_BLK_HI:`MMD_BLK_LO]))
        else $error("lower dual blocks misdecoded in data space");

    chk_data_upper_map: assert property (
        data_req && data_addr[`MMD_BLK_HI]
        |=> data_target == ($past(mode_status[`MMD_DATAMAP_BIT]) ? MMD_TGT_DUAL : MMD_TGT_EXT))
        else $error("upper data half ignores mapping bit");

    chk_rom_page_zero: assert property (
        prog_req && !mode_status[`MMD_ROMEN_BIT] && page_select == `MMD_PAGE_BASE
        && prog_addr >= `MMD_ROM_BASE |=> prog_target == MMD_TGT_ROM)
        else $error("enabled rom not decoded");

    chk_host_write_free: assert property (
        host_req && host_we |=> host_grant && !host_refused)
        else $error("host write refused");

    chk_rom_only_host: assert property (
        host_req && !secure_ram_rom |=> host_grant && !host_refused)
        else $error("host access refused without ram/rom option");

    chk_emu_open: assert property (
        !secure_any |=> emu_enable && bscan_enable)
        else $error("emulation off without security");

endmodule : mmd_decoder
`default_nettype wire

// ---- src/mmd_map_if.sv ----
// mapping controls passed from the register file to the decoders
`timescale 1ns/100ps
`default_nettype none
interface mmd_map_if;
    logic [6:0] page;
    logic       overlay;
    logic       datamap;
    logic       rom_off;

    modport ctrl (output page, output overlay, output datamap, output rom_off);
    modport dec  (input page, input overlay, input datamap, input rom_off);
endinterface : mmd_map_if
`default_nettype wire

// ---- src/mmd_pkg.sv ----
// types shared by the memory map decoder modules
package mmd_pkg;

    // one-hot access destination
    typedef enum logic [4:0] {
        MMD_TGT_EXT    = 5'h01,
        MMD_TGT_ROM    = 5'h02,
        MMD_TGT_DUAL   = 5'h04,
        MMD_TGT_SINGLE = 5'h08,
        MMD_TGT_REG    = 5'h10
    } mmd_target_type;

    // whole state of the top module
    typedef struct packed {
        logic           boot;
        logic [6:0]     page;
        logic [15:0]    mode;
        logic           prog_valid;
        mmd_target_type prog_target;
        logic [2:0]     prog_block;
        logic [22:0]    prog_full;
        logic           prog_ones;
        logic           data_valid;
        mmd_target_type data_target;
        logic [2:0]     data_block;
        logic [15:0]    rdata;
        logic           pc_load;
        logic [15:0]    pc_value;
        logic           host_grant;
        logic           host_refused;
        logic           emu_en;
        logic           bscan_en;
    } mmd_state_type;

endpackage : mmd_pkg

// ---- src/mmd_prog_decode.sv ----
// program space address decoder
`timescale 1ns/100ps
`default_nettype none
`include "mmd_cfg.svh"
module mmd_prog_decode
    import mmd_pkg::*;
(
    // mapping controls
    mmd_map_if.dec              map,
    // address in
    input  wire logic [15:0]    addr,
    // decode result
    output mmd_target_type      target,
    output logic [2:0]          block,
    output logic [22:0]         full
);

    // page-extended address steered to rom, dual, single or external memory
    always_comb begin
        full   = {map.page, addr};
        target = MMD_TGT_EXT;
        block  = `MMD_ZERO_BLK;
        if (map.page == `MMD_PAGE_BASE && addr >= `MMD_ROM_BASE && !map.rom_off) begin
            target = MMD_TGT_ROM;
        end else if (map.page == `MMD_PAGE_DUAL_HI && addr[`MMD_BLK_HI]) begin
            target = MMD_TGT_DUAL;
            block  = addr[`MMD_BLK_HI:`MMD_BLK_LO];
        end else if ((map.page == `MMD_PAGE_SINGLE_A || map.page == `MMD_PAGE_SINGLE_B)
                     && addr[`MMD_BLK_HI]) begin
            target = MMD_TGT_SINGLE;
            block  = {map.page[0], addr[`MMD_BLK_MID:`MMD_BLK_LO]};
        end else if (map.overlay && !addr[`MMD_BLK_HI] && addr >= `MMD_DUAL_LO) begin
            target = MMD_TGT_DUAL;
            block  = addr[`MMD_BLK_HI:`MMD_BLK_LO];
        end
    end

endmodule : mmd_prog_decode
`default_nettype wire
